// File: rtl/escr_pkg.sv
// Package for the extended system-control register bank
package escr_pkg;

  // ==========================================================================
  // I/O port addresses
  localparam logic [15:0] ESCR_PORT_LOCK     = 16'h03c3;
  localparam logic [15:0] ESCR_PORT_INDEX    = 16'h03c4;
  localparam logic [15:0] ESCR_PORT_DATA     = 16'h03c5;
  localparam logic [15:0] ESCR_PORT_CRT_MONO = 16'h03b5;
  localparam logic [15:0] ESCR_PORT_CRT_COLR = 16'h03d5;

  // ==========================================================================
  // Unlock pattern on bits 7:5 of the lock byte
  localparam logic [2:0] ESCR_UNLOCK_PAT = 3'h2;
  localparam int         ESCR_UNLOCK_LSB = 5;

  // ==========================================================================
  // Register indices
  localparam logic [7:0] ESCR_IDX_ADDR0 = 8'h10;
  localparam logic [7:0] ESCR_IDX_ADDR1 = 8'h11;
  localparam logic [7:0] ESCR_IDX_ADDR2 = 8'h12;
  localparam logic [7:0] ESCR_IDX_ADDR3 = 8'h13;
  localparam logic [7:0] ESCR_IDX_MISC  = 8'h15;
  localparam logic [7:0] ESCR_IDX_GCMD1 = 8'h17;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] ESCR_MISC_RST  = 8'h00;
  localparam logic [7:0] ESCR_GCMD1_RST = 8'h00;
  localparam logic [7:0] ESCR_ADDR_RST  = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int ESCR_ADDR0_BOS_BIT   = 0;
  localparam int ESCR_MISC_BURST_BIT  = 7;
  localparam int ESCR_MISC_SWAB_BIT   = 5;
  localparam int ESCR_MISC_ENGAB_BIT  = 4;
  localparam int ESCR_MISC_SSLOCK_BIT = 3;
  localparam int ESCR_MISC_VAR_BIT    = 0;
  localparam logic [7:0] ESCR_MISC_WMASK = 8'hb9;
  localparam int ESCR_GCMD1_BURST_BIT = 5;

  // ==========================================================================
  // Host I/O request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } escr_io_req_t;

  // Control outputs to the rest of the device
  typedef struct packed {
    logic [31:0] master_start_addr;
    logic        byte_order_select;
    logic        burst_read_enable;
    logic        burst_enable;
    logic        engine_abort_enable;
    logic        software_abort_enable;
    logic        subsys_id_lock;
    logic        variant_select;
  } escr_ctrl_t;

endpackage

// File: rtl/escr_port_decode.sv
// Port decoder for the extended register I/O addresses
`timescale 1ns/1ps
`default_nettype none

module escr_port_decode (
  // Request
  input  wire logic [15:0] addr_in,
  input  wire logic        colour_mode_in,
  // Decode
  output logic             hit_lock_out,
  output logic             hit_index_out,
  output logic             hit_data_out
);
  import escr_pkg::*;

  // ==========================================================================
  // Decode
  always_comb begin
    hit_lock_out  = (addr_in == ESCR_PORT_LOCK);
    hit_index_out = (addr_in == ESCR_PORT_INDEX);
    hit_data_out  = (addr_in == ESCR_PORT_DATA) ||
                    (colour_mode_in ? (addr_in == ESCR_PORT_CRT_COLR)
                                    : (addr_in == ESCR_PORT_CRT_MONO));
  end

endmodule
`default_nettype wire

// File: rtl/escr_regs.sv
// Extended system-control register bank on the host I/O ports
// What this block does
// - Decode lock port, data port and mono/colour CRT data port.
// - Index register selects extended register; data port reads/writes it.
// - All registers run on the bus system clock only.
// - Registers stay accessible while memory and video clocks stop.
// - Index 10h bits 7:1 hold master start address bits 7:1.
// - Index 10h bit 0 selects bi-endian byte order.
// - Index 11h holds master start address bits 15:8.
// - Index 12h holds master start address bits 23:16.
// - Index 13h holds master start address bits 31:24.
// - Start address registers reset to 00h.
// - Control register at index 15h resets to 00h.
// - Burst read only when control bit 7 and burst enable both set.
// - Control bit 4 enables drawing engine abort.
// - Control bit 5 enables software abort, only with bit 4 set.
// - Control bit 3 enables subsystem identifier lock.
// - Control bit 0 selects the device variant.
// - Command register bit 5 enables bus bursts globally.
`timescale 1ns/1ps
`default_nettype none

module escr_regs (
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_b_in,
  input  wire logic                 clk_en_in,
  // Host I/O
  input  wire escr_pkg::escr_io_req_t io_req_in,
  input  wire logic                 colour_mode_in,
  output logic [7:0]                io_rdata_out,
  output logic                      io_rvalid_out,
  // Controls
  output escr_pkg::escr_ctrl_t      ctrl_out,
  output logic                      unlocked_out
);
  import escr_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    logic        unlocked;
    logic [7:0]  index;
    logic [7:0]  addr0;
    logic [7:0]  addr1;
    logic [7:0]  addr2;
    logic [7:0]  addr3;
    logic [7:0]  misc;
    logic [7:0]  gcmd1;
    logic [7:0]  rdata;
    logic        rvalid;
    escr_ctrl_t  ctrl;
  } escr_state_t;

  escr_state_t state_r;
  escr_state_t state_nxt;
  logic        hit_lock;
  logic        hit_index;
  logic        hit_data;
  logic [7:0]  rd_val;

  // ==========================================================================
  // Port decode
  escr_port_decode u_dec (
    .addr_in        (io_req_in.addr),
    .colour_mode_in (colour_mode_in),
    .hit_lock_out   (hit_lock),
    .hit_index_out  (hit_index),
    .hit_data_out   (hit_data)
  );

  // ==========================================================================
  // Read mux
  always_comb begin
    rd_val = 8'h00;
    if (hit_lock) begin
      rd_val = {state_r.unlocked ? ESCR_UNLOCK_PAT : 3'h0, 5'h00};
    end else if (hit_index) begin
      rd_val = state_r.index;
    end else if (hit_data && state_r.unlocked) begin
      case (state_r.index)
        ESCR_IDX_ADDR0: rd_val = state_r.addr0;
        ESCR_IDX_ADDR1: rd_val = state_r.addr1;
        ESCR_IDX_ADDR2: rd_val = state_r.addr2;
        ESCR_IDX_ADDR3: rd_val = state_r.addr3;
        ESCR_IDX_MISC:  rd_val = state_r.misc & ESCR_MISC_WMASK;
        ESCR_IDX_GCMD1: rd_val = state_r.gcmd1;
        default:        rd_val = 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // Next state
  always_comb begin
    state_nxt        = state_r;
    state_nxt.rvalid = 1'b0;
    if (io_req_in.rd) begin
      state_nxt.rdata  = rd_val;
      state_nxt.rvalid = 1'b1;
    end
    if (io_req_in.wr) begin
      if (hit_lock) begin
        state_nxt.unlocked = (io_req_in.wdata[7:ESCR_UNLOCK_LSB] == ESCR_UNLOCK_PAT);
      end else if (hit_index) begin
        state_nxt.index = io_req_in.wdata;
      end else if (hit_data && state_r.unlocked) begin
        case (state_r.index)
          ESCR_IDX_ADDR0: state_nxt.addr0 = io_req_in.wdata;
          ESCR_IDX_ADDR1: state_nxt.addr1 = io_req_in.wdata;
          ESCR_IDX_ADDR2: state_nxt.addr2 = io_req_in.wdata;
          ESCR_IDX_ADDR3: state_nxt.addr3 = io_req_in.wdata;
          ESCR_IDX_MISC:  state_nxt.misc  = io_req_in.wdata & ESCR_MISC_WMASK;
          ESCR_IDX_GCMD1: state_nxt.gcmd1 = io_req_in.wdata;
          default:        state_nxt.index = state_r.index;
        endcase
      end
    end
    // Control decode, registered
    state_nxt.ctrl.master_start_addr =
      {state_nxt.addr3, state_nxt.addr2, state_nxt.addr1,
       state_nxt.addr0[7:1], 1'b0};
    state_nxt.ctrl.byte_order_select = state_nxt.addr0[ESCR_ADDR0_BOS_BIT];
    state_nxt.ctrl.burst_enable = state_nxt.gcmd1[ESCR_GCMD1_BURST_BIT];
    state_nxt.ctrl.burst_read_enable = state_nxt.misc[ESCR_MISC_BURST_BIT] &
                                       state_nxt.gcmd1[ESCR_GCMD1_BURST_BIT];
    state_nxt.ctrl.engine_abort_enable = state_nxt.misc[ESCR_MISC_ENGAB_BIT];
    state_nxt.ctrl.software_abort_enable = state_nxt.misc[ESCR_MISC_SWAB_BIT] &
                                           state_nxt.misc[ESCR_MISC_ENGAB_BIT];
    state_nxt.ctrl.subsys_id_lock = state_nxt.misc[ESCR_MISC_SSLOCK_BIT];
    state_nxt.ctrl.variant_select = state_nxt.misc[ESCR_MISC_VAR_BIT];
  end

  // ==========================================================================
  // Registers on the bus clock, independent of memory and video clocks
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r       <= '0;
      state_r.addr0 <= ESCR_ADDR_RST;
      state_r.misc  <= ESCR_MISC_RST;
      state_r.gcmd1 <= ESCR_GCMD1_RST;
    end else if (clk_en_in) begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  always_comb begin
    io_rdata_out  = state_r.rdata;
    io_rvalid_out = state_r.rvalid;
    ctrl_out      = state_r.ctrl;
    unlocked_out  = state_r.unlocked;
  end

endmodule
`default_nettype wire

// File: dv/escr_regs_monitor.sv
// Checker for the register bank ports
`timescale 1ns/1ps
`default_nettype none
module escr_regs_monitor (
  // Watched ports
  input wire logic                   clk_in,
  input wire logic                   rst_b_in,
  input wire logic                   clk_en_in,
  input wire escr_pkg::escr_io_req_t io_req_in,
  input wire logic [7:0]             io_rdata_out,
  input wire logic                   io_rvalid_out,
  input wire escr_pkg::escr_ctrl_t   ctrl_out,
  input wire logic                   unlocked_out
);
  import escr_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  logic wr, rd, op;
  assign wr = io_req_in.wr && clk_en_in;
  assign rd = io_req_in.rd && clk_en_in;
  assign op = io_req_in.wdata[7:5] == ESCR_UNLOCK_PAT;
  sequence s_lock; wr && io_req_in.addr == ESCR_PORT_LOCK; endsequence
  chk_read_answer: assert property (rd |=> io_rvalid_out)
    else $error("read not answered");
  chk_no_stray: assert property (io_rvalid_out |-> $past(rd))
    else $error("stray read valid");
  chk_unlock_open: assert property (s_lock ##0 op |=> unlocked_out)
    else $error("bank not unlocked");
  chk_relock_shut: assert property (s_lock ##0 !op |=> !unlocked_out)
    else $error("bank not relocked");
  chk_locked_zero: assert property (
    rd && !wr && !unlocked_out && io_req_in.addr == ESCR_PORT_DATA |=> io_rdata_out == 8'h00)
    else $error("locked read not zero");
  chk_burst_gate: assert property (
    ctrl_out.burst_read_enable |-> ctrl_out.burst_enable) else $error("burst ungated");
  chk_abort_gate: assert property (
    ctrl_out.software_abort_enable |-> ctrl_out.engine_abort_enable) else $error("abort ungated");
  chk_ctrl_hold: assert property (!wr |=> $stable(ctrl_out))
    else $error("control moved");
endmodule
bind escr_regs escr_regs_monitor u_mon (.clk_in(clk_in), .rst_b_in(rst_b_in),
  .clk_en_in(clk_en_in), .io_req_in(io_req_in), .io_rdata_out(io_rdata_out),
  .io_rvalid_out(io_rvalid_out), .ctrl_out(ctrl_out), .unlocked_out(unlocked_out));
`default_nettype wire

// File: dv/escr_host_model.sv
// Host model issuing I/O cycles to the bank
`timescale 1ns/1ps
`default_nettype none
module escr_host_model (
  // Bus
  input  wire logic              clk_in,
  input  wire logic [7:0]        io_rdata_in,
  input  wire logic              io_rvalid_in,
  output escr_pkg::escr_io_req_t io_req_out,
  output logic                   clk_en_out
);
  import escr_pkg::*;
  initial io_req_out = '0;
  assign clk_en_out = 1'h1;
  // One strobe, then strobes low with inverted address and data driven
  task automatic cycle(input logic w, input logic [15:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic v);
    @(posedge clk_in);
    io_req_out <= {w, ~w, a, d};
    @(posedge clk_in);
    io_req_out <= {2'h0, ~a, ~d};
    #1;
    q = io_rdata_in;
    v = io_rvalid_in;
  endtask
  task automatic unlock(output logic [7:0] q, output logic v);
    cycle(1'h1, ESCR_PORT_LOCK, {ESCR_UNLOCK_PAT, 5'h15}, q, v);
  endtask
endmodule
`default_nettype wire

// File: dv/test_escr_regs.sv
// Self-checking testbench for the register bank
`timescale 1ns/1ps
`default_nettype none
module test_escr_regs;
  import escr_pkg::*;
  logic         clk_in = 1'h0;
  logic         rst_b_in = 1'h0;
  logic         clk_en, rvalid, unlocked, v;
  logic         colour = 1'h1;
  logic [7:0]   rdata, q;
  escr_io_req_t io_req;
  escr_ctrl_t   ctrl;
  int           num_errors = 0, tests_run = 0, cyc = 0;
  // Index, data written, data read back
  logic [23:0]  rows [7] = '{24'h10a5a5, 24'h113c3c, 24'h125a5a, 24'h13c3c3,
                             24'h15ffb9, 24'h172020, 24'h147700};
  always #12.5 clk_in = ~clk_in;
  escr_regs dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en),
    .io_req_in(io_req), .colour_mode_in(colour), .io_rdata_out(rdata),
    .io_rvalid_out(rvalid), .ctrl_out(ctrl), .unlocked_out(unlocked));
  escr_host_model host (.clk_in(clk_in), .io_rdata_in(rdata), .io_rvalid_in(rvalid),
    .io_req_out(io_req), .clk_en_out(clk_en));
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic conclude;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic rio(input logic w, input logic [7:0] i, input logic [7:0] d);
    host.cycle(1'h1, ESCR_PORT_INDEX, i, q, v);
    host.cycle(w, ESCR_PORT_DATA, d, q, v);
    @(posedge clk_in);
    #1;
    if (!w) check("rvalid", 32'h1, 32'(v));
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    repeat (12) @(posedge clk_in);
    rst_b_in <= 1'h1;
    rio(1'h0, 8'h13, 8'h00);
    check("locked read", 32'h0, 32'(q));
    host.unlock(q, v);
    check("unlocked", 32'h1, 32'(unlocked));
    rio(1'h0, 8'h15, 8'h00);
    check("misc reset", 32'h0, 32'(q));
    foreach (rows[k]) begin
      rio(1'h1, rows[k][23:16], rows[k][15:8]);
      rio(1'h0, rows[k][23:16], 8'h00);
      check("row read", 32'(rows[k][7:0]), 32'(q));
    end
    check("start addr", 32'hc35a3ca4, ctrl.master_start_addr);
    check("ctrl bits", 32'h7f, 32'(ctrl[6:0]));
    rio(1'h1, 8'h17, 8'h00);
    rio(1'h1, 8'h15, 8'h20);
    check("ctrl gated", 32'h40, 32'(ctrl[6:0]));
    host.cycle(1'h1, ESCR_PORT_LOCK, 8'h00, q, v);
    rio(1'h1, 8'h11, 8'h00);
    check("locked write", 32'hc35a3ca4, ctrl.master_start_addr);
    // Data port aliases in colour and mono mode
    host.unlock(q, v);
    host.cycle(1'h1, ESCR_PORT_INDEX, 8'h13, q, v);
    host.cycle(1'h1, ESCR_PORT_CRT_COLR, 8'h81, q, v);
    check("colour alias", 32'h815a3ca4, ctrl.master_start_addr);
    colour <= 1'h0;
    host.cycle(1'h1, ESCR_PORT_CRT_MONO, 8'h42, q, v);
    check("mono alias", 32'h425a3ca4, ctrl.master_start_addr);
    host.cycle(1'h1, ESCR_PORT_CRT_COLR, 8'h00, q, v);
    check("colour off", 32'h425a3ca4, ctrl.master_start_addr);
    // Reset in mid-run
    @(posedge clk_in);
    rst_b_in <= 1'h0;
    @(posedge clk_in);
    rst_b_in <= 1'h1;
    #1;
    check("reset lock", 32'h0, 32'(unlocked));
    check("reset ctrl", 32'h0, 32'(ctrl[6:0]));
    host.unlock(q, v);
    rio(1'h0, 8'h15, 8'h00);
    check("misc rereset", 32'h0, 32'(q));
    conclude();
  end
endmodule
`default_nettype wire
